// *** src/tag_ctl_defines.svh ***
// tag_ctl_defines.svh: timing counts and widths for the tag memory controller
// assumes a 20 MHz system clock (50 ns period)
`ifndef TAG_CTL_DEFINES_SVH
`define TAG_CTL_DEFINES_SVH

`define CLK_PERIOD_PS 50000
`define WORD_SEL_W 12
`define TAG_W 4
// device timing in ps, fastest grade
`define ADDR_TO_HIT_PS 10000
`define DATA_TO_HIT_PS 8000
`define HIT_HOLD_AFTER_ADDR_PS 3000
`define DRIVE_ACCESS_DELAY_PS 7000
`define STROBE_TO_FLOAT_DELAY_PS 5000
`define ADDR_VALID_TO_END_PS 8000
`define DATA_VALID_TO_END_PS 6000
`define WRITE_PULSE_PS 8000
`define STROBE_HIGH_BEFORE_WIPE_RELEASE_PS 5000
`define WIPE_PULSE_WIDTH_PS 12000
`define WIPE_RECOVERY_PS 5000
// least times round up to whole cycles, at least one
`define CYC_MIN(ps) ((((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS) < 1 ? 1 : \
  (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS))
// wipe duty cycle at most one in ten: wipe low for n, then high for 9n
`define WIPE_DUTY_FACTOR 9
`define CNT_W 8

`endif

// *** src/tag_ctl_pkg.sv ***
// tag_ctl_pkg: types for the tag memory controller
// assumes tag_ctl_defines.svh is compiled first
`include "tag_ctl_defines.svh"
package tag_ctl_pkg;
  typedef enum logic [1:0] {
    OP_MATCH = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ  = 2'h2,
    OP_WIPE  = 2'h3
  } op_e;
  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_SETUP   = 7'h02,
    ST_STROBE  = 7'h04,
    ST_SETTLE  = 7'h08,
    ST_SAMPLE  = 7'h10,
    ST_RECOVER = 7'h20,
    ST_DONE    = 7'h40
  } seq_e;
  typedef logic [`CNT_W-1:0] cnt_t;
endpackage

// *** src/tag_sync_if.sv ***
// tag_sync_if: synchronised device answers passed between controller modules
// assumes one clock domain
`timescale 1ns/1ps
interface tag_sync_if #(parameter int TW = 4);
  logic [TW-1:0] tag_q;
  logic hit_q;
  modport sync (output tag_q, output hit_q);
  modport user (input tag_q, input hit_q);
endinterface

// *** src/tag_pin_sync.sv ***
// tag_pin_sync: two-flop synchroniser for the device hit and tag pins
// assumes asynchronous pin inputs
`timescale 1ns/1ps
module tag_pin_sync #(
  parameter int TW = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [TW-1:0] tag_in,
  input wire logic hit_in,
  tag_sync_if.sync sy
);
  logic [TW:0] s1_reg, s1_next, s2_reg, s2_next;
  always_comb begin
    s1_next = {hit_in, tag_in};
    s2_next = s1_reg;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
    end
  end
  assign sy.tag_q = s2_reg[TW-1:0];
  assign sy.hit_q = s2_reg[TW];
endmodule

// *** src/tag_ctl.sv ***
// tag_ctl: controller driving an asynchronous 4k x 4 tag memory with comparator
// assumes a 20 MHz clock; device pins are asynchronous to it
//
// Notes on behaviour
// - strobe high whenever address changes
// - write pulse covers float plus setup
// - never drive tag bits while device drives
// - address, data set up before strobe ends
// - strobe high before wipe release; duty
// - keep address driven always; data driven from a write or match until the next read
`timescale 1ns/1ps
`include "tag_ctl_defines.svh"
module tag_ctl
  import tag_ctl_pkg::*;
#(
  parameter int AW = `WORD_SEL_W,
  parameter int TW = `TAG_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // command port
  input wire logic req_valid,
  input wire logic [1:0] req_op,
  input wire logic [AW-1:0] req_addr,
  input wire logic [TW-1:0] req_tag,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_hit,
  output logic [TW-1:0] rsp_tag,
  // device pins
  output logic [AW-1:0] word_select,
  output logic [TW-1:0] tag_bits_out,
  output logic tag_bits_oe_n,
  input wire logic [TW-1:0] tag_bits_in,
  output logic write_strobe_n,
  output logic drive_n,
  output logic wipe_all_n,
  input wire logic hit
);
  // ----------------------------------------
  // timing counts
  // ----------------------------------------
  // hit and read data must pass two sync flops, so settle time is only the device delay
  localparam cnt_t SETTLE_HIT = cnt_t'(`CYC_MIN(`ADDR_TO_HIT_PS > `DATA_TO_HIT_PS ?
    `ADDR_TO_HIT_PS : `DATA_TO_HIT_PS));
  localparam cnt_t SETTLE_READ = cnt_t'(`CYC_MIN(`DRIVE_ACCESS_DELAY_PS));
  localparam cnt_t SETUP_WR = cnt_t'(`CYC_MIN(`ADDR_VALID_TO_END_PS));
  localparam cnt_t PULSE_WR = cnt_t'(`CYC_MIN(`STROBE_TO_FLOAT_DELAY_PS + `DATA_VALID_TO_END_PS >
    `WRITE_PULSE_PS ? `STROBE_TO_FLOAT_DELAY_PS + `DATA_VALID_TO_END_PS : `WRITE_PULSE_PS));
  // one less than the least width: the setup state itself holds the wipe low for a cycle
  localparam cnt_t PULSE_WIPE = cnt_t'(`CYC_MIN(`WIPE_PULSE_WIDTH_PS) - 1);
  localparam cnt_t GAP_WIPE = cnt_t'(`CYC_MIN(`STROBE_HIGH_BEFORE_WIPE_RELEASE_PS));
  localparam cnt_t RECOV_WIPE = cnt_t'(`WIPE_DUTY_FACTOR * `CYC_MIN(`WIPE_PULSE_WIDTH_PS));
  localparam cnt_t RECOV_RD = cnt_t'(`CYC_MIN(`DRIVE_ACCESS_DELAY_PS));

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  tag_sync_if #(.TW(TW)) sy ();
  tag_pin_sync #(.TW(TW)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .tag_in(tag_bits_in),
    .hit_in(hit),
    .sy(sy)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  seq_e st_reg, st_next;
  op_e op_reg, op_next;
  cnt_t cnt_reg, cnt_next;
  logic [AW-1:0] addr_reg, addr_next;
  logic [TW-1:0] dout_reg, dout_next;
  logic oe_n_reg, oe_n_next, we_n_reg, we_n_next, rd_n_reg, rd_n_next, wipe_n_reg, wipe_n_next;
  logic rdy_reg, rdy_next, rv_reg, rv_next, rh_reg, rh_next;
  logic [TW-1:0] rt_reg, rt_next;

  always_comb begin
    st_next = st_reg;
    op_next = op_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    dout_next = dout_reg;
    oe_n_next = oe_n_reg;
    we_n_next = we_n_reg;
    rd_n_next = rd_n_reg;
    wipe_n_next = wipe_n_reg;
    rdy_next = rdy_reg;
    rv_next = 1'b0;
    rh_next = rh_reg;
    rt_next = rt_reg;
    if (cnt_reg != '0) begin
      cnt_next = cnt_reg - cnt_t'(1);
    end
    case (st_reg)
      ST_IDLE: begin
        // ready comes up one edge after reset lets go
        rdy_next = 1'b1;
        if (req_valid && rdy_reg) begin
          rdy_next = 1'b0;
          op_next = op_e'(req_op);
          // address moves only while strobe is high
          addr_next = req_addr;
          dout_next = req_tag;
          st_next = ST_SETUP;
          cnt_next = '0;
          case (op_e'(req_op))
            OP_WIPE: begin
              wipe_n_next = 1'b0;
              cnt_next = PULSE_WIPE;
            end
            OP_READ: begin
              // let go of the shared pins before the device drives them
              oe_n_next = 1'b1;
            end
            default: begin
              oe_n_next = 1'b0;
            end
          endcase
        end
      end
      ST_SETUP: begin
        case (op_reg)
          OP_WIPE: begin
            if (cnt_reg == '0) begin
              wipe_n_next = 1'b1;
              cnt_next = RECOV_WIPE;
              st_next = ST_RECOVER;
            end
          end
          OP_WRITE: begin
            we_n_next = 1'b0;
            cnt_next = PULSE_WR;
            st_next = ST_STROBE;
          end
          OP_READ: begin
            rd_n_next = 1'b0;
            cnt_next = SETTLE_READ;
            st_next = ST_SETTLE;
          end
          default: begin
            cnt_next = SETTLE_HIT;
            st_next = ST_SETTLE;
          end
        endcase
      end
      ST_STROBE: begin
        // pulse covers address and data setup to the rising strobe edge
        if (cnt_reg == '0) begin
          we_n_next = 1'b1;
          cnt_next = GAP_WIPE;
          st_next = ST_RECOVER;
        end
      end
      ST_SETTLE: begin
        // hold-time margin is far below one clock, so old hit never leaks in
        if (cnt_reg == '0) begin
          cnt_next = cnt_t'(2);
          st_next = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        // two more cycles for the synchroniser to carry the settled pins
        if (cnt_reg == '0) begin
          rv_next = 1'b1;
          rh_next = sy.hit_q;
          rt_next = (op_reg == OP_READ) ? sy.tag_q : dout_reg;
          if (op_reg == OP_READ) begin
            rd_n_next = 1'b1;
            cnt_next = RECOV_RD;
            st_next = ST_RECOVER;
          end else begin
            st_next = ST_DONE;
          end
        end
      end
      ST_RECOVER: begin
        if (cnt_reg == '0) begin
          if (op_reg != OP_READ) begin
            rv_next = 1'b1;
            rh_next = 1'b0;
            rt_next = dout_reg;
          end
          st_next = ST_DONE;
        end
      end
      ST_DONE: begin
        rdy_next = 1'b1;
        st_next = ST_IDLE;
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= ST_IDLE;
      op_reg <= OP_MATCH;
      cnt_reg <= '0;
      addr_reg <= '0;
      dout_reg <= '0;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      wipe_n_reg <= 1'b1;
      rdy_reg <= 1'b0;
      rv_reg <= 1'b0;
      rh_reg <= 1'b0;
      rt_reg <= '0;
    end else begin
      st_reg <= st_next;
      op_reg <= op_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      dout_reg <= dout_next;
      oe_n_reg <= oe_n_next;
      we_n_reg <= we_n_next;
      rd_n_reg <= rd_n_next;
      wipe_n_reg <= wipe_n_next;
      rdy_reg <= rdy_next;
      rv_reg <= rv_next;
      rh_reg <= rh_next;
      rt_reg <= rt_next;
    end
  end

  // ----------------------------------------
  // outputs, all from flops
  // ----------------------------------------
  assign req_ready = rdy_reg;
  assign rsp_valid = rv_reg;
  assign rsp_hit = rh_reg;
  assign rsp_tag = rt_reg;
  assign word_select = addr_reg;
  assign tag_bits_out = dout_reg;
  assign tag_bits_oe_n = oe_n_reg;
  assign write_strobe_n = we_n_reg;
  assign drive_n = rd_n_reg;
  assign wipe_all_n = wipe_n_reg;
endmodule

// *** bench/tag_dev_model.sv ***
// tag_dev_model: behavioural 4k x 4 tag memory with comparator
// assumes the controller's split tag pins; no clock of its own
`timescale 1ns/1ps
module tag_dev_model (
  // device pins
  input wire logic [11:0] word_select,
  input wire logic [3:0] tag_bits_out,
  input wire logic tag_bits_oe_n,
  input wire logic write_strobe_n,
  input wire logic drive_n,
  input wire logic wipe_all_n,
  output logic [3:0] tag_bits_in,
  output logic hit
);
  logic [3:0] mem [4096];
  logic dev_drv;
  logic [3:0] wire_lvl;
  // ------------------
  // pins and compare
  // ------------------
  assign dev_drv = !drive_n && write_strobe_n && wipe_all_n;
  // a released wire shows the inverse, so a stale value cannot pass
  assign wire_lvl = dev_drv ? mem[word_select] : (!tag_bits_oe_n ? tag_bits_out : ~tag_bits_out);
  assign #7 tag_bits_in = wire_lvl;
  // inertial delay keeps the old answer well past the hold time
  assign #8 hit = (mem[word_select] == wire_lvl);
  always @(posedge write_strobe_n) begin
    if (wipe_all_n) begin
      mem[word_select] = wire_lvl;
    end
  end
  always @(negedge wipe_all_n) begin
    foreach (mem[i]) mem[i] = 4'h0;
  end
endmodule

// *** bench/tag_ctl_chk.sv ***
// tag_ctl_chk: pin-level checks on the tag memory controller
// assumes binding into tag_ctl, one clock domain
`timescale 1ns/1ps
module tag_ctl_chk #(parameter int AW = 12, parameter int TW = 4) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // command port
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rsp_valid,
  // device pins
  input wire logic [AW-1:0] word_select,
  input wire logic [TW-1:0] tag_bits_out,
  input wire logic tag_bits_oe_n,
  input wire logic write_strobe_n,
  input wire logic drive_n,
  input wire logic wipe_all_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------
  // assertions
  // ----------
  property p_addr_steady; !$stable(word_select) |-> write_strobe_n && $past(write_strobe_n); endproperty
  a_addr_steady: assert property (p_addr_steady) else $error("address moved near strobe");
  property p_wr_data; !write_strobe_n |-> $stable(tag_bits_out) && !tag_bits_oe_n; endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data not held");
  property p_wr_len; $fell(write_strobe_n) |-> ##[1:4] write_strobe_n; endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe too long");
  property p_rd_nodrive; !drive_n |-> tag_bits_oe_n; endproperty
  a_rd_nodrive: assert property (p_rd_nodrive) else $error("bus fight in read");
  property p_wipe_alone; !wipe_all_n |-> write_strobe_n && drive_n; endproperty
  a_wipe_alone: assert property (p_wipe_alone) else $error("strobe during wipe");
  property p_wipe_duty; $rose(wipe_all_n) |-> wipe_all_n[*8] ##1 wipe_all_n; endproperty
  a_wipe_duty: assert property (p_wipe_duty) else $error("wipe duty too high");
  property p_cmd_answer; req_valid && req_ready |=> !req_ready ##[0:19] rsp_valid; endproperty
  a_cmd_answer: assert property (p_cmd_answer) else $error("no answer");
  property p_one_at_time; rsp_valid |-> !req_ready; endproperty
  a_one_at_time: assert property (p_one_at_time) else $error("ready with answer");
  c_answer: cover property (rsp_valid);
  c_read: cover property ($fell(drive_n));
  c_wipe: cover property ($fell(wipe_all_n));
endmodule
bind tag_ctl tag_ctl_chk #(.AW(AW), .TW(TW)) u_tag_ctl_chk (.clk(clk), .sys_rst(sys_rst),
  .req_valid(req_valid), .req_ready(req_ready), .rsp_valid(rsp_valid), .word_select(word_select),
  .tag_bits_out(tag_bits_out), .tag_bits_oe_n(tag_bits_oe_n), .write_strobe_n(write_strobe_n),
  .drive_n(drive_n), .wipe_all_n(wipe_all_n));

// *** bench/tb_tag_ctl.sv ***
// tb_tag_ctl: self-checking bench for the tag memory controller
// assumes tag_dev_model on the device pins and the bound checker
`timescale 1ns/1ps
module tb_tag_ctl;
  import tag_ctl_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic [1:0] req_op = 2'h0;
  logic [11:0] req_addr = 12'h000;
  logic [3:0] req_tag = 4'h0;
  logic req_ready, rsp_valid, rsp_hit, tag_bits_oe_n, write_strobe_n, drive_n, wipe_all_n, hit, got_hit;
  logic [3:0] rsp_tag, tag_bits_out, tag_bits_in, got_tag;
  logic [11:0] word_select;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  tag_ctl u_tag_ctl (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_tag(req_tag), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_hit(rsp_hit), .rsp_tag(rsp_tag), .word_select(word_select), .tag_bits_out(tag_bits_out),
    .tag_bits_oe_n(tag_bits_oe_n), .tag_bits_in(tag_bits_in), .write_strobe_n(write_strobe_n),
    .drive_n(drive_n), .wipe_all_n(wipe_all_n), .hit(hit));
  tag_dev_model u_tag_dev_model (.word_select(word_select), .tag_bits_out(tag_bits_out),
    .tag_bits_oe_n(tag_bits_oe_n), .write_strobe_n(write_strobe_n), .drive_n(drive_n),
    .wipe_all_n(wipe_all_n), .tag_bits_in(tag_bits_in), .hit(hit));
  // ----------
  // helpers
  // ----------
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one command; a missing answer is itself a mismatch
  task automatic do_cmd(input op_e op, input logic [11:0] a, input logic [3:0] t);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    req_op = op;
    req_addr = a;
    req_tag = t;
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({3'h0, rsp_valid}, 4'h1);
    got_hit = rsp_hit;
    got_tag = rsp_tag;
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic t_write_match();
    do_cmd(OP_WRITE, 12'hABC, 4'h5);
    check({3'h0, got_hit}, 4'h0);
    do_cmd(OP_MATCH, 12'hABC, 4'h5);
    check({3'h0, got_hit}, 4'h1);
    check(got_tag, 4'h5);
    do_cmd(OP_MATCH, 12'hABC, 4'h4);
    check({3'h0, got_hit}, 4'h0);
    $display("test write_match done");
  endtask
  task automatic t_read_back();
    do_cmd(OP_WRITE, 12'hFFF, 4'hF);
    do_cmd(OP_WRITE, 12'h000, 4'h3);
    do_cmd(OP_READ, 12'hFFF, 4'h0);
    check(got_tag, 4'hF);
    do_cmd(OP_READ, 12'h000, 4'h0);
    check(got_tag, 4'h3);
    do_cmd(OP_MATCH, 12'hABC, 4'h5);
    check({3'h0, got_hit}, 4'h1);
    $display("test read_back done");
  endtask
  task automatic t_wipe();
    do_cmd(OP_WIPE, 12'h000, 4'h0);
    check({3'h0, got_hit}, 4'h0);
    do_cmd(OP_READ, 12'hABC, 4'h0);
    check(got_tag, 4'h0);
    do_cmd(OP_MATCH, 12'hFFF, 4'h0);
    check({3'h0, got_hit}, 4'h1);
    $display("test wipe done");
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_write_match();
    t_read_back();
    t_wipe();
    report_and_stop();
  end
endmodule
